// ---- hdl/sac_pkg.sv ----
package sac_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned RES_BITS = 10;
  localparam int unsigned UPPER_BITS = 8;
  localparam int unsigned LOWER_BITS = 2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned START_MIN_WIDTH_NS = 500;
  localparam int unsigned DONE_RISE_MAX_NS = 1500;
  localparam int unsigned CONV_MAX_NS = 30000;
  localparam int unsigned DONE_RISE_MAX_CYC = DONE_RISE_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned START_MIN_CYC =
    (START_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [9:0] TRIAL_RST = 10'h000;
  localparam logic [9:0] TRIAL_MSB = 10'h200;
  localparam logic [3:0] BIT_IDX_MSB = 4'h9;
  localparam logic [3:0] BIT_IDX_RST = 4'h0;
  localparam logic DONE_N_RST = 1'b0;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CLEAR = 4'b0010,
    ST_TRIAL = 4'b0100,
    ST_DONE  = 4'b1000
  } sac_state_type;

endpackage

// ---- hdl/sac_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Two-stage synchroniser
// ****************************************
module sac_sync
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic async_i,
  output logic sync_o
);

  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule // sac_sync

`default_nettype wire

// ---- hdl/sac_convert.sv ----
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Start rise resets logic, done_n high quickly
// - Trials begin on start falling edge
// - Trial bits MSB to LSB, comparator clears
// - done_n falls after last trial
// - Byte enables low drive result bits
// - Range tied low: unipolar straight binary
// - Range open: bipolar offset binary coding
// - Enables during conversion show partial result
// - Start rise clears previous result
module sac_convert
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic upper_byte_oe_n_i,
  input wire logic lower_byte_oe_n_i,
  input wire logic range_open_i,
  input wire logic cmp_above_i,
  output logic [9:0] dac_code_o,
  output logic bipolar_offset_o,
  output logic done_n_o,
  output logic done_n_oe_o,
  output logic [7:0] upper_data_o,
  output logic [7:0] upper_data_oe_o,
  output logic [1:0] lower_data_o,
  output logic [1:0] lower_data_oe_o
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic start_s;
  logic upper_rd_s;
  logic lower_rd_s;
  logic range_open_s;

  // Enables inverted so that reset leaves the buffers floating
  sac_sync u_sync_start (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .async_i(start_i), .sync_o(start_s));
  sac_sync u_sync_upper (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .async_i(~upper_byte_oe_n_i), .sync_o(upper_rd_s));
  sac_sync u_sync_lower (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .async_i(~lower_byte_oe_n_i), .sync_o(lower_rd_s));
  sac_sync u_sync_range (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .async_i(range_open_i), .sync_o(range_open_s));

  // ****************************************
  // Edge detection
  // ****************************************
  logic start_d_ff;
  wire start_rise = start_s & ~start_d_ff;
  wire start_fall = ~start_s & start_d_ff;

  // ****************************************
  // State and trial register
  // ****************************************
  sac_pkg::sac_state_type state_ff;
  sac_pkg::sac_state_type nxt_state;
  logic [9:0] trial_result_register_ff;
  logic [9:0] nxt_trial;
  logic [3:0] bit_idx_ff;
  logic [3:0] nxt_bit_idx;
  logic done_n_ff;
  logic [7:0] upper_q_ff;
  logic [1:0] lower_q_ff;

  wire [9:0] bit_mask = 10'h001 << bit_idx_ff;
  wire [9:0] trial_kept = trial_result_register_ff & ~(cmp_above_i ? bit_mask : 10'h000);
  wire [9:0] trial_next_bit = trial_kept | (bit_mask >> 1);
  wire last_trial = (bit_idx_ff == sac_pkg::BIT_IDX_RST);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_trial = trial_result_register_ff;
    nxt_bit_idx = bit_idx_ff;
    if (start_rise)
    begin
      nxt_state = sac_pkg::ST_CLEAR;
      nxt_trial = sac_pkg::TRIAL_RST;
      nxt_bit_idx = sac_pkg::BIT_IDX_MSB;
    end
    else
    begin
      case (state_ff)
        sac_pkg::ST_CLEAR:
        begin
          if (start_fall)
          begin
            nxt_state = sac_pkg::ST_TRIAL;
            nxt_trial = sac_pkg::TRIAL_MSB;
          end
        end
        sac_pkg::ST_TRIAL:
        begin
          if (last_trial)
          begin
            nxt_trial = trial_kept;
            nxt_state = sac_pkg::ST_DONE;
          end
          else
          begin
            nxt_trial = trial_next_bit;
            nxt_bit_idx = bit_idx_ff - 4'h1;
          end
        end
        default:
        begin
          nxt_state = state_ff;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      start_d_ff <= 1'b0;
      state_ff <= sac_pkg::ST_IDLE;
      trial_result_register_ff <= sac_pkg::TRIAL_RST;
      bit_idx_ff <= sac_pkg::BIT_IDX_RST;
      done_n_ff <= sac_pkg::DONE_N_RST;
      upper_q_ff <= 8'h00;
      lower_q_ff <= 2'h0;
    end
    else
    begin
      start_d_ff <= start_s;
      state_ff <= nxt_state;
      trial_result_register_ff <= nxt_trial;
      bit_idx_ff <= nxt_bit_idx;
      done_n_ff <= (nxt_state != sac_pkg::ST_DONE) && (nxt_state != sac_pkg::ST_IDLE);
      upper_q_ff <= nxt_trial[9:2];
      lower_q_ff <= nxt_trial[1:0];
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign dac_code_o = trial_result_register_ff;
  assign bipolar_offset_o = range_open_s;
  assign done_n_o = 1'b0;
  assign done_n_oe_o = ~done_n_ff;
  assign upper_data_o = upper_q_ff;
  assign lower_data_o = lower_q_ff;
  assign upper_data_oe_o = {8{upper_rd_s}};
  assign lower_data_oe_o = {2{lower_rd_s}};

  // ****************************************
  // Checks
  // ****************************************
  property p_done_rise;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      start_rise |-> ##[1:150] done_n_ff;
  endproperty
  a_done_rise: assert property (p_done_rise) else $error("done_n not high after start");

  property p_clear;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      start_rise |=> trial_result_register_ff == 10'h000;
  endproperty
  a_clear: assert property (p_clear) else $error("result not cleared");

  property p_wait_fall;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (state_ff == sac_pkg::ST_CLEAR) && start_s && !start_rise |=> state_ff == sac_pkg::ST_CLEAR;
  endproperty
  a_wait_fall: assert property (p_wait_fall) else $error("trials began while start high");

  property p_msb_first;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (state_ff == sac_pkg::ST_CLEAR) && start_fall |=> trial_result_register_ff == 10'h200;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("MSB trial not first");

  // Cycles spent in trials, counted apart from the bit index
  logic [3:0] trial_cyc_ff;

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      trial_cyc_ff <= 4'h0;
    end
    else
    begin
      trial_cyc_ff <= (state_ff == sac_pkg::ST_TRIAL) ? trial_cyc_ff + 4'h1 : 4'h0;
    end
  end

  property p_ten_cycles;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (state_ff == sac_pkg::ST_TRIAL) && !start_rise
        |=> (state_ff == sac_pkg::ST_DONE) == (trial_cyc_ff == 4'(sac_pkg::RES_BITS));
  endproperty
  a_ten_cycles: assert property (p_ten_cycles) else $error("conversion not ten cycles");

  property p_done_low;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      state_ff == sac_pkg::ST_DONE |-> !done_n_ff && done_n_oe_o;
  endproperty
  a_done_low: assert property (p_done_low) else $error("done_n not low when done");

  property p_drive;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      upper_rd_s |-> upper_data_oe_o == 8'hff && upper_data_o == trial_result_register_ff[9:2];
  endproperty
  a_drive: assert property (p_drive) else $error("upper byte not driven");

  property p_float;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      !lower_rd_s |-> lower_data_oe_o == 2'h0;
  endproperty
  a_float: assert property (p_float) else $error("lower byte not floated");

  property p_range;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      bipolar_offset_o == $past(range_open_i, 2);
  endproperty
  a_range: assert property (p_range) else $error("range mode wrong");

  c_conv: cover property (@(posedge core_clk_i) state_ff == sac_pkg::ST_DONE);
  c_partial: cover property (@(posedge core_clk_i)
    state_ff == sac_pkg::ST_TRIAL && upper_rd_s);
  c_restart: cover property (@(posedge core_clk_i)
    state_ff == sac_pkg::ST_TRIAL && start_rise);
  c_full: cover property (@(posedge core_clk_i)
    state_ff == sac_pkg::ST_DONE && trial_result_register_ff == 10'h3ff);

endmodule // sac_convert

`default_nettype wire

// ---- verif/sac_cmp_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Comparator and ready line model
// ****************************************
module sac_cmp_model
(
  input wire logic [9:0] dac_code_i,
  input wire logic [9:0] vin_code_i,
  input wire logic done_n_oe_i,
  output logic cmp_above_o,
  output logic done_n_o
);
  // Input given as the expected code, offset binary when bipolar
  assign cmp_above_o = dac_code_i > vin_code_i;
  // Pull-up unless the block sinks the line
  assign done_n_o = done_n_oe_i ? 1'b0 : 1'b1;
endmodule // sac_cmp_model

`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic start = 1'b0;
  logic ube_n = 1'b1;
  logic lbe_n = 1'b1;
  logic rng = 1'b0;
  logic [9:0] vin = 10'h000;
  logic cmp, bip, done_oe, done_n, done_dat;
  logic [9:0] dac;
  logic [7:0] up, up_oe;
  logic [1:0] lo, lo_oe;
  int errors = 0;
  int comparisons = 0;

  always #5 clk = ~clk;

  sac_convert DUT (.core_clk_i(clk), .sys_rst_i(sys_rst), .start_i(start),
    .upper_byte_oe_n_i(ube_n), .lower_byte_oe_n_i(lbe_n), .range_open_i(rng),
    .cmp_above_i(cmp), .dac_code_o(dac), .bipolar_offset_o(bip), .done_n_o(done_dat),
    .done_n_oe_o(done_oe), .upper_data_o(up), .upper_data_oe_o(up_oe),
    .lower_data_o(lo), .lower_data_oe_o(lo_oe));

  sac_cmp_model u_cmp (.dac_code_i(dac), .vin_code_i(vin), .done_n_oe_i(done_oe),
    .cmp_above_o(cmp), .done_n_o(done_n));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_done(input logic lvl, input int lim, output int n);
    n = 0;
    while (done_n !== lvl && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask

  task automatic test_done();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk("done after reset", 10'h000, {9'h000, done_n});
    chk("done data", 10'h000, {9'h000, done_dat});
    chk("oe after reset", 10'h000, {up_oe, lo_oe});
  endtask

  task automatic t_convert(input logic [9:0] v, input logic r);
    int n;
    vin = v;
    rng = r;
    start = 1'b1;
    wait_done(1'b1, 150, n);
    chk("done high", 10'h001, {9'h000, done_n});
    chk("cleared", 10'h000, dac);
    cyc(50);
    chk("idle while high", 10'h000, dac);
    chk("range", {9'h000, r}, {9'h000, bip});
    start = 1'b0;
    wait_done(1'b0, 40, n);
    chk("trial span", 10'h001, {9'h000, n >= 11 && n <= 16});
    chk("result", v, dac);
    ube_n = 1'b0;
    lbe_n = 1'b0;
    cyc(4);
    chk("upper", {2'h0, v[9:2]}, {2'h0, up});
    chk("upper oe", 10'h0ff, {2'h0, up_oe});
    chk("lower", {8'h00, v[1:0]}, {8'h00, lo});
    chk("lower oe", 10'h003, {8'h00, lo_oe});
    ube_n = 1'b1;
    lbe_n = 1'b1;
    cyc(4);
    chk("float", 10'h000, {up_oe, lo_oe});
  endtask

  task automatic t_partial();
    int n;
    vin = 10'h000;
    start = 1'b1;
    cyc(50);
    start = 1'b0;
    cyc(7);
    ube_n = 1'b0;
    cyc(3);
    // Seven decisions made, bit 2 under trial
    chk("busy", 10'h001, {9'h000, done_n});
    chk("partial oe", 10'h0ff, {2'h0, up_oe});
    chk("partial", 10'h001, {2'h0, up});
    ube_n = 1'b1;
    wait_done(1'b0, 40, n);
    chk("partial done", 10'h000, {9'h000, done_n});
    chk("partial result", 10'h000, dac);
    cyc(4);
  endtask

  task automatic t_blind(input logic [9:0] v);
    vin = v;
    start = 1'b1;
    cyc(int'(sac_pkg::START_MIN_CYC));
    start = 1'b0;
    cyc(int'(sac_pkg::CONV_MAX_NS / sac_pkg::CLK_PERIOD_NS));
    ube_n = 1'b0;
    lbe_n = 1'b0;
    cyc(4);
    chk("blind upper", {2'h0, v[9:2]}, {2'h0, up});
    chk("blind lower", {8'h00, v[1:0]}, {8'h00, lo});
    ube_n = 1'b1;
    lbe_n = 1'b1;
    cyc(4);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    cyc(8);
    sys_rst = 1'b0;
    cyc(1);
    t_reset();
    t_convert(10'h3ff, 1'b0);
    t_convert(10'h000, 1'b1);
    t_convert(10'h200, 1'b1);
    t_convert(10'h155, 1'b0);
    t_partial();
    t_blind(10'h2a6);
    test_done();
  end

  initial
  begin
    #200000;
    errors++;
    test_done();
  end
endmodule // testbench

`default_nettype wire
